// >>> rtl/ppc_engine.sv
`timescale 1ns/1ps
// How it works
// - two-bit width code picks 4, 8, 16 or 32 us pulses; default 1
// - stretch bit makes every pulse sixteen times longer
// - count field plus one is the pulse limit per cycle; default 15
// - automatic control adds pulses until limit or near saturation
// - automatic control ends integration early for very near or far targets
// - with automatic control disabled exactly the programmed count plus one is emitted
// - two-bit gain code gives 1x, 2x, 4x, 8x; default 2
// - drive code 0..8 selects 2..19 mA, doubled while the trim bit is low; codes above 8 reserved (clamped to code 8 here)
module ppc_engine
   import ppc_pkg::*;
#(
   parameter int COUNT_W = 6
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // photodiode front end
   input wire logic near_saturation,
   input wire logic target_extreme,
   // emitter driver
   output logic emitter_on,
   output logic [5:0] emitter_milliamps,
   output logic [1:0] prox_sensor_gain,
   output logic cycle_done,
   output logic [COUNT_W:0] pulses_sent
);
   // ************************************************
   // registers
   // ************************************************
   logic [7:0] general_config_zero, next_general_config_zero;
   logic [7:0] proximity_pulse_config, next_proximity_pulse_config;
   logic [7:0] proximity_gain_drive, next_proximity_gain_drive;
   logic [7:0] general_config_one, next_general_config_one;
   logic [7:0] general_config_six, next_general_config_six;
   logic prox_enable, next_prox_enable;
   logic start_req, next_start_req;
   logic [31:0] next_prdata;
   logic wr, rd, hit;
   logic [7:0] a8;
   logic busy;
   assign pready = 1'b1;
   // registers sit on word indices; the byte address is four times the index
   assign a8 = paddr[9:2];
   assign wr = psel && penable && pwrite && pstrb[0];
   // read data loads at the setup edge, so it stands from a flop through the zero-wait access phase
   assign rd = psel && !penable && !pwrite;
   assign hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
      (a8 == ADDR_GENERAL_CONFIG_ZERO || a8 == ADDR_PULSE_CONFIG || a8 == ADDR_GAIN_DRIVE ||
       a8 == ADDR_GENERAL_CONFIG_ONE || a8 == ADDR_GENERAL_CONFIG_SIX ||
       a8 == ADDR_PROX_CONTROL || a8 == ADDR_PROX_STATUS);
   assign pslverr = psel && penable && !hit;
   always_comb begin
      next_general_config_zero = general_config_zero;
      next_proximity_pulse_config = proximity_pulse_config;
      next_proximity_gain_drive = proximity_gain_drive;
      next_general_config_one = general_config_one;
      next_general_config_six = general_config_six;
      next_prox_enable = prox_enable;
      next_start_req = start_req;
      next_prdata = prdata;
      if (cycle_done) begin
         next_start_req = 1'b0;
      end
      if (wr && hit) begin
         if (a8 == ADDR_GENERAL_CONFIG_ZERO) begin
            next_general_config_zero = pwdata[7:0];
         end else if (a8 == ADDR_PULSE_CONFIG) begin
            next_proximity_pulse_config = pwdata[7:0];
         end else if (a8 == ADDR_GAIN_DRIVE) begin
            next_proximity_gain_drive = pwdata[7:0];
         end else if (a8 == ADDR_GENERAL_CONFIG_ONE) begin
            next_general_config_one = pwdata[7:0];
         end else if (a8 == ADDR_GENERAL_CONFIG_SIX) begin
            next_general_config_six = pwdata[7:0];
         end else if (a8 == ADDR_PROX_CONTROL) begin
            next_prox_enable = pwdata[POS_ENABLE];
            if (pwdata[POS_START]) begin
               next_start_req = 1'b1;
            end
         end
      end
      if (rd) begin
         if (!hit) begin
            next_prdata = 32'h0000_0000;
         end else if (a8 == ADDR_GENERAL_CONFIG_ZERO) begin
            next_prdata = {24'h00_0000, general_config_zero};
         end else if (a8 == ADDR_PULSE_CONFIG) begin
            next_prdata = {24'h00_0000, proximity_pulse_config};
         end else if (a8 == ADDR_GAIN_DRIVE) begin
            next_prdata = {24'h00_0000, proximity_gain_drive};
         end else if (a8 == ADDR_GENERAL_CONFIG_ONE) begin
            next_prdata = {24'h00_0000, general_config_one};
         end else if (a8 == ADDR_GENERAL_CONFIG_SIX) begin
            next_prdata = {24'h00_0000, general_config_six};
         end else if (a8 == ADDR_PROX_CONTROL) begin
            next_prdata = {30'h0000_0000, prox_enable, start_req};
         end else if (a8 == ADDR_PROX_STATUS) begin
            next_prdata = 32'({pulses_sent, busy});
         end else begin
            next_prdata = 32'h0000_0000;
         end
      end
   end
   // ************************************************
   // sequencer
   // ************************************************
   ppc_state_t state, next_state;
   logic [COUNT_W-1:0] lim, next_lim;
   logic [COUNT_W:0] sent, next_sent;
   logic [15:0] tmr, next_tmr;
   logic [15:0] width_cyc, next_width_cyc;
   logic auto_on, next_auto_on;
   logic [1:0] gain_q, next_gain_q;
   logic [3:0] drv_q, next_drv_q;
   logic dbl_q, next_dbl_q;
   logic done_q, next_done_q;
   logic [15:0] sel_width;
   localparam logic [COUNT_W:0] ONE_PULSE = {{COUNT_W{1'b0}}, 1'b1};
   assign busy = (state != ST_IDLE);
   always_comb begin
      // width in cycles: base << code, then << 4 when stretched
      sel_width = 16'(BASE_PULSE_CYC) << proximity_pulse_config[POS_WIDTH_SEL +: 2];
      if (general_config_zero[POS_STRETCH]) begin
         sel_width = sel_width << STRETCH_SHIFT;
      end
      next_state = state;
      next_lim = lim;
      next_sent = sent;
      next_tmr = tmr;
      next_width_cyc = width_cyc;
      next_auto_on = auto_on;
      next_gain_q = gain_q;
      next_drv_q = drv_q;
      next_dbl_q = dbl_q;
      next_done_q = 1'b0;
      case (state)
         ST_IDLE: begin
            // a one-shot start is still set while cycle_done stands; without the mask it would rerun
            if (prox_enable || (start_req && !cycle_done)) begin
               // snapshot so mid-cycle writes cannot disturb it
               next_lim = proximity_pulse_config[COUNT_W-1:0];
               next_width_cyc = sel_width;
               next_auto_on = !general_config_six[POS_AUTO_PULSE_OFF];
               next_gain_q = proximity_gain_drive[POS_GAIN +: 2];
               next_drv_q = (proximity_gain_drive[3:0] > MAX_DRIVE_CODE) ? MAX_DRIVE_CODE
                  : proximity_gain_drive[3:0];
               next_dbl_q = general_config_one[POS_CURRENT_DOUBLE_N];
               next_sent = '0;
               next_tmr = sel_width - 16'h0001;
               next_state = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (tmr == 16'h0000) begin
               next_sent = sent + ONE_PULSE;
               next_tmr = 16'(GAP_CYC - 1);
               next_state = ST_GAP;
            end else begin
               next_tmr = tmr - 16'h0001;
            end
         end
         default: begin
            if (tmr != 16'h0000) begin
               next_tmr = tmr - 16'h0001;
            end else if (sent == {1'b0, lim} + ONE_PULSE) begin
               next_done_q = 1'b1;
               next_state = ST_IDLE;
            end else if (auto_on && (near_saturation || target_extreme)) begin
               next_done_q = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_tmr = width_cyc - 16'h0001;
               next_state = ST_PULSE;
            end
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_config_zero <= RST_GENERAL_CONFIG_ZERO;
         proximity_pulse_config <= RST_PULSE_CONFIG;
         proximity_gain_drive <= RST_GAIN_DRIVE;
         general_config_one <= RST_GENERAL_CONFIG_ONE;
         general_config_six <= RST_GENERAL_CONFIG_SIX;
         prox_enable <= 1'b0;
         start_req <= 1'b0;
         prdata <= 32'h0000_0000;
         state <= ST_IDLE;
         lim <= '0;
         sent <= '0;
         tmr <= 16'h0000;
         width_cyc <= 16'h0000;
         auto_on <= 1'b0;
         gain_q <= RST_GAIN_DRIVE[POS_GAIN +: 2];
         drv_q <= 4'h0;
         dbl_q <= 1'b0;
         done_q <= 1'b0;
      end else if (clk_en) begin
         general_config_zero <= next_general_config_zero;
         proximity_pulse_config <= next_proximity_pulse_config;
         proximity_gain_drive <= next_proximity_gain_drive;
         general_config_one <= next_general_config_one;
         general_config_six <= next_general_config_six;
         prox_enable <= next_prox_enable;
         start_req <= next_start_req;
         prdata <= next_prdata;
         state <= next_state;
         lim <= next_lim;
         sent <= next_sent;
         tmr <= next_tmr;
         width_cyc <= next_width_cyc;
         auto_on <= next_auto_on;
         gain_q <= next_gain_q;
         drv_q <= next_drv_q;
         dbl_q <= next_dbl_q;
         done_q <= next_done_q;
      end
   end
   assign emitter_on = (state == ST_PULSE);
   assign cycle_done = done_q;
   assign pulses_sent = sent;
   assign prox_sensor_gain = gain_q;
   ppc_drive_map u_map (
      .code(drv_q),
      .double_n(dbl_q),
      .milliamps(emitter_milliamps)
   );
endmodule

// >>> rtl/ppc_pkg.sv
package ppc_pkg;
   // ************************************************
   // register word indices; the byte address is four times the index
   // ************************************************
   localparam logic [7:0] ADDR_GENERAL_CONFIG_ZERO = 8'h8d;
   localparam logic [7:0] ADDR_PULSE_CONFIG = 8'h8e;
   localparam logic [7:0] ADDR_GAIN_DRIVE = 8'h8f;
   localparam logic [7:0] ADDR_GENERAL_CONFIG_ONE = 8'h90;
   localparam logic [7:0] ADDR_GENERAL_CONFIG_SIX = 8'ha0;
   localparam logic [7:0] ADDR_PROX_CONTROL = 8'ha4;
   localparam logic [7:0] ADDR_PROX_STATUS = 8'ha8;
   // ************************************************
   // reset values
   // ************************************************
   localparam logic [7:0] RST_GENERAL_CONFIG_ZERO = 8'h40;
   localparam logic [7:0] RST_PULSE_CONFIG = 8'h4f;
   localparam logic [7:0] RST_GAIN_DRIVE = 8'h80;
   localparam logic [7:0] RST_GENERAL_CONFIG_ONE = 8'h09;
   localparam logic [7:0] RST_GENERAL_CONFIG_SIX = 8'h00;
   // ************************************************
   // field positions
   // ************************************************
   localparam int POS_WIDTH_SEL = 6;
   localparam int POS_STRETCH = 0;
   localparam int POS_AUTO_PULSE_OFF = 6;
   localparam int POS_GAIN = 6;
   localparam int POS_CURRENT_DOUBLE_N = 5;
   localparam int POS_START = 0;
   localparam int POS_ENABLE = 1;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_MHZ = 40;
   localparam int BASE_PULSE_NS = 4000;
   localparam int BASE_PULSE_CYC = (BASE_PULSE_NS * CLK_MHZ) / 1000;
   localparam int STRETCH_SHIFT = 4;
   localparam int GAP_NS = 1000;
   localparam int GAP_CYC = (GAP_NS * CLK_MHZ) / 1000;
   localparam logic [3:0] MAX_DRIVE_CODE = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_GAP = 3'b100
   } ppc_state_t;
endpackage

// >>> rtl/ppc_drive_map.sv
`timescale 1ns/1ps
// emitter current code to milliamps, doubled when the trim bit is low
module ppc_drive_map
   import ppc_pkg::*;
(
   input wire logic [3:0] code,
   input wire logic double_n,
   output logic [5:0] milliamps
);
   logic [4:0] nominal;
   always_comb begin
      case (code)
         4'h0: nominal = 5'h02;
         4'h1: nominal = 5'h04;
         4'h2: nominal = 5'h06;
         4'h3: nominal = 5'h08;
         4'h4: nominal = 5'h0a;
         4'h5: nominal = 5'h0c;
         4'h6: nominal = 5'h0e;
         4'h7: nominal = 5'h11;
         4'h8: nominal = 5'h13;
         default: nominal = 5'h00;
      endcase
      milliamps = double_n ? {1'b0, nominal} : {nominal, 1'b0};
   end
endmodule

// >>> dv/ppc_engine_properties.sv
`timescale 1ns/1ps
// ***
// engine port checks
// ***
module ppc_engine_checker
   import ppc_pkg::*;
#(
   parameter int COUNT_W = 6
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // engine outputs
   input wire logic emitter_on,
   input wire logic [5:0] emitter_milliamps,
   input wire logic [1:0] prox_sensor_gain,
   input wire logic cycle_done,
   input wire logic [COUNT_W:0] pulses_sent
);
   logic [14:0] on_len;
   logic [14:0] next_on_len;
   always_comb begin
      next_on_len = emitter_on ? on_len + 15'h0001 : 15'h0000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_len <= 15'h0000;
      end else begin
         on_len <= next_on_len;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence on_run_s;
      emitter_on [*8];
   endsequence
   sequence off_run_s;
      !emitter_on [*8];
   endsequence
   width_code_a: assert property ($fell(emitter_on) |-> on_len inside
      {15'h00a0, 15'h0140, 15'h0280, 15'h0500, 15'h0a00, 15'h1400, 15'h2800, 15'h5000}) else $error("bad width");
   on_min_a: assert property ($rose(emitter_on) |-> on_run_s) else $error("pulse too short");
   gap_min_a: assert property ($fell(emitter_on) |-> off_run_s) else $error("gap too short");
   count_range_a: assert property (cycle_done |-> pulses_sent >= 1 && pulses_sent <= 64)
      else $error("count out of range");
   done_quiet_a: assert property (cycle_done |-> !emitter_on ##1 !cycle_done) else $error("done misplaced");
   gain_hold_a: assert property (emitter_on && $past(emitter_on) |-> $stable(prox_sensor_gain))
      else $error("gain moved in pulse");
   drive_hold_a: assert property (emitter_on && $past(emitter_on) |-> $stable(emitter_milliamps))
      else $error("drive moved in pulse");
   drive_map_a: assert property (emitter_on |-> emitter_milliamps inside {6'h11, 6'h13, 6'h22, 6'h26} ||
      (!emitter_milliamps[0] && emitter_milliamps inside {[6'h02:6'h1c]})) else $error("bad drive");
endmodule
bind ppc_engine ppc_engine_checker #(.COUNT_W(COUNT_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .emitter_on(emitter_on), .emitter_milliamps(emitter_milliamps), .prox_sensor_gain(prox_sensor_gain),
   .cycle_done(cycle_done), .pulses_sent(pulses_sent));

// >>> dv/ppc_front_end.sv
`timescale 1ns/1ps
// ***
// photodiode front end model
// ***
module ppc_front_end (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // engine side
   input wire logic emitter_on,
   input wire logic cycle_done,
   // bench control, zero never trips
   input wire logic [6:0] trip_after,
   input wire logic trip_kind,
   // front end flags
   output logic near_saturation,
   output logic target_extreme
);
   logic [6:0] seen;
   logic on_d;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= 7'h00;
         on_d <= 1'b0;
      end else begin
         on_d <= emitter_on;
         if (cycle_done) begin
            seen <= 7'h00;
         end else if (on_d && !emitter_on) begin
            seen <= seen + 7'h01;
         end
      end
   end
   // flag stays up until the cycle ends, as a real saturated diode would
   assign near_saturation = trip_after != 7'h00 && seen >= trip_after && !trip_kind;
   assign target_extreme = trip_after != 7'h00 && seen >= trip_after && trip_kind;
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
   import ppc_pkg::*;
   typedef struct {int width; int pulses; logic [1:0] gain; int ma;} ppc_exp_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trip_kind = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, near_saturation, target_extreme, emitter_on, cycle_done, e;
   logic [5:0] emitter_milliamps;
   logic [1:0] prox_sensor_gain;
   logic [6:0] pulses_sent, trip_after = 7'h00;
   ppc_exp_t exp_q[$];
   int n_mismatch = 0, checks_done = 0, seed = 63005, cyc = 0, on_len = 0;
   always #12.5 pclk = ~pclk;
   ppc_engine #(.COUNT_W(6)) dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .near_saturation(near_saturation), .target_extreme(target_extreme),
      .emitter_on(emitter_on), .emitter_milliamps(emitter_milliamps), .prox_sensor_gain(prox_sensor_gain),
      .cycle_done(cycle_done), .pulses_sent(pulses_sent));
   ppc_front_end fe (.pclk(pclk), .presetn(presetn), .emitter_on(emitter_on), .cycle_done(cycle_done),
      .trip_after(trip_after), .trip_kind(trip_kind), .near_saturation(near_saturation),
      .target_extreme(target_extreme));
   task automatic bad(input string msg);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // register index times four gives the byte address
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= 32'(wd);
      @(posedge pclk);
      penable <= 1'b1;
      // the wait ends on the first edge with pready high; only the bench timeout ends it otherwise
      do begin
         @(posedge pclk);
         e = pslverr;
         rd = prdata;
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] r;
      apb(1'b1, idx, wd, r);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [31:0] x);
      logic [31:0] r;
      apb(1'b0, idx, 8'h00, r);
      checks_done++;
      if (r !== x) bad("read value");
   endtask
   always @(negedge pclk) begin
      if (emitter_on === 1'b1) on_len++;
      else if (on_len != 0) begin
         checks_done++;
         if (exp_q.size() == 0 || on_len != exp_q[0].width) bad("pulse width");
         checks_done++;
         if (exp_q.size() == 0 || prox_sensor_gain !== exp_q[0].gain ||
            emitter_milliamps !== exp_q[0].ma) bad("setup");
         on_len = 0;
      end
      if (cycle_done === 1'b1) begin
         checks_done++;
         if (exp_q.size() == 0 || pulses_sent !== exp_q[0].pulses) bad("pulse count");
         if (exp_q.size() != 0) exp_q.pop_front();
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 100000) begin
         bad("timeout");
         finish_test();
      end
   end
   initial begin
      logic [1:0] w;
      logic [5:0] c;
      logic [3:0] d;
      ppc_exp_t x;
      repeat (5) @(posedge pclk);
      checks_done++;
      if (emitter_milliamps !== 6'h04) bad("reset drive");
      presetn <= 1'b1;
      rc(ADDR_PULSE_CONFIG, 32'h0000_004f);
      rc(ADDR_GAIN_DRIVE, 32'h0000_0080);
      rc(8'h91, 32'h0000_0000);
      checks_done++;
      if (e !== 1'b1) bad("no error on unmapped");
      wr(ADDR_GENERAL_CONFIG_ONE, 8'h29);
      wr(ADDR_GENERAL_CONFIG_SIX, 8'h40);
      for (int i = 0; i < 13; i++) begin
         w = (i < 10) ? 2'(i) : 2'b00;
         c = (i == 9) ? 6'h3f : (i > 9) ? 6'h03 : 6'($random(seed) & 3);
         d = (i < 10) ? 4'(i % 9) : 4'h7;
         if (i > 9) wr(ADDR_GENERAL_CONFIG_SIX, (i == 12) ? 8'h40 : 8'h00);
         // last cycle leaves the trim bit low on purpose to see the current double
         if (i == 12) wr(ADDR_GENERAL_CONFIG_ONE, 8'h09);
         trip_kind <= (i == 11);
         trip_after <= (i > 9) ? 7'(13 - i) : 7'h00;
         wr(ADDR_GENERAL_CONFIG_ZERO, (i == 8) ? 8'h41 : 8'h40);
         wr(ADDR_PULSE_CONFIG, {w, c});
         wr(ADDR_GAIN_DRIVE, {w, 2'b00, d});
         x.width = (160 << w) << ((i == 8) ? 4 : 0);
         x.pulses = (i == 10 || i == 11) ? 13 - i : c + 1;
         x.gain = w;
         x.ma = ((d < 7) ? 2 * (d + 1) : (d == 7) ? 17 : 19) * ((i == 12) ? 2 : 1);
         exp_q.push_back(x);
         wr(ADDR_PROX_CONTROL, 8'h01);
         wr(ADDR_PULSE_CONFIG, 8'($random(seed)));
         wr(ADDR_GAIN_DRIVE, {2'($random(seed)), 6'h08});
         while (exp_q.size() != 0) @(posedge pclk);
      end
      // idle after four pulses: count in the upper field, busy low
      rc(ADDR_PROX_STATUS, 32'h0000_0008);
      finish_test();
   end
endmodule
